// [core/pss_pkg.sv]
// package: constants and carriers of the supply supervisor and sequencer
package pss_pkg;
    // ------------------------------------------------------------------
    // channels and clocking
    // ------------------------------------------------------------------
    localparam int NUM_CHAN = 6;      // hv buck 1/2, lv buck 1/2, ldo 1/2
    localparam int NUM_BUCK = 4;      // channels 0..3 are bucks
    localparam int NUM_HV = 2;        // channels 0..1 face hv_supply_inputs
    localparam int CH_HV2 = 1;        // second high-voltage regulator
    localparam int CLK_HZ = 50_000_000;
    // ------------------------------------------------------------------
    // times in their own units and derived cycle counts
    // ------------------------------------------------------------------
    localparam int POR_DELAY_MS = 100;
    localparam int POR_DELAY_CYC = CLK_HZ / 1000 * POR_DELAY_MS;
    localparam int SW_FREQ_KHZ = 1200;
    localparam int SW_CYC = CLK_HZ / 1000 / SW_FREQ_KHZ; // rounds down
    localparam int SS_STEP_US = 10;
    localparam int SS_STEP_CYC = CLK_HZ / 1_000_000 * SS_STEP_US;
    localparam int SEQ_US = 50;
    localparam int SEQ_CYC = CLK_HZ / 1_000_000 * SEQ_US;
    localparam int PFM_DIV = 4;       // light-load cycle skipping ratio
    localparam int POR_CW = 23;
    localparam int SEQ_CW = 12;
    localparam int SS_CW = 9;
    localparam int SW_CW = 6;
    localparam int PFM_CW = 3;
    localparam int STEP_W = 3;
    localparam logic [STEP_W-1:0] STEP_MAX = 3'h7; // full current limit
    // ------------------------------------------------------------------
    // sequencer states, gray along reset -> power-up -> active
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_RESET = 2'h0,
        SEQ_POWERUP = 2'h1,
        SEQ_ACTIVE = 2'h3
    } pss_seq_t;
    // comparator and pin levels, all asynchronous to clk
    typedef struct packed {
        logic [NUM_CHAN-1:0] supplyOk;     // above undervoltage_protect
        logic [NUM_CHAN-1:0] chanEnable;   // bit 1 is hv_reg2_enable
        logic [NUM_HV-1:0] supplyOver;     // overvoltage_protect trips
        logic overTemp;
        logic hvReg2OutputGood;            // hv_reg2_output above 91 %
        logic [NUM_BUCK-1:0] lightLoad;
        logic [NUM_BUCK-1:0] currentTrip;  // peak limit comparator
        logic [NUM_BUCK-1:0] shortDetect;
        logic [NUM_BUCK-1:0] currentLow;   // inductor current decayed
        logic lnbSupplyOk;
        logic lnbBoostEnable;
        logic lnbLevelSelect;
    } pss_in_t;
    // regulator controls
    typedef struct packed {
        logic [NUM_CHAN-1:0] chanRun;
        logic [NUM_CHAN-1:0][STEP_W-1:0] limitStep;
        logic [NUM_BUCK-1:0] highSide;
        logic [NUM_BUCK-1:0] lowSide;
        logic [NUM_BUCK-1:0] pulseFrequencyOperation;
        logic lnbRun;
        logic lnbHighLevel;
    } pss_out_t;
endpackage

// [core/pss_supervisor_sequencer.sv]
// module: supply supervisor, fault sequencer and host power-on reset
`timescale 1ns/1ps
module pss_supervisor_sequencer #(
    parameter int PorDelayCyc = pss_pkg::POR_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // comparator and pin levels
    input wire pss_pkg::pss_in_t pinIn,
    // regulator controls
    output pss_pkg::pss_out_t ctrlOut,
    // open-drain host reset pin
    output logic porOut,
    output logic porOe,
    // status
    output pss_pkg::pss_seq_t seqState
);
    import pss_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pss_in_t syncA;
        pss_in_t syncB;
        pss_seq_t seq;
        logic [SEQ_CW-1:0] seqCnt;
        logic [NUM_CHAN-1:0][SS_CW-1:0] ssCnt;
        logic [SW_CW-1:0] swCnt;
        logic [PFM_CW-1:0] pfmCnt;
        logic [NUM_BUCK-1:0] shortHold;
        logic [POR_CW-1:0] porCnt;
        logic porRelease;
        pss_out_t out;
    } pss_state_t;

    pss_state_t st_r;
    pss_state_t st_nxt;
    pss_in_t s;
    logic fault;
    logic swTick;
    logic pfmTick;
    logic [NUM_CHAN-1:0] chanGo;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // a counter sits on the last count of a period of the given length
    function automatic logic atLast(input logic [31:0] cnt, input int len);
        return cnt == 32'(len - 1);
    endfunction

    // pins are asynchronous; reading stage one would risk metastable values
    // synchronised view; only the second stage is read
    assign s = st_r.syncB;

    // over-temperature or any hv overvoltage holds the reset state
    assign fault = s.overTemp | (|s.supplyOver);

    // hysteresis lives in the analog comparators; levels are taken as is
    // each channel needs its own supply and enable, and an active device
    assign chanGo = (st_r.seq == SEQ_ACTIVE) ? (s.supplyOk & s.chanEnable)
                                             : '0;

    // switching period edge and light-load divided edge
    // the period rounds down, so the rate sits slightly above nominal
    assign swTick = atLast(32'(st_r.swCnt), SW_CYC);
    assign pfmTick = swTick && (st_r.pfmCnt == '0);

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.syncA = pinIn;
        st_nxt.syncB = st_r.syncA;

        // --------------------------------------------------------------
        // free-running switching timebase
        // --------------------------------------------------------------
        st_nxt.swCnt = swTick ? '0 : st_r.swCnt + SW_CW'(1);
        if (swTick) begin
            st_nxt.pfmCnt = atLast(32'(st_r.pfmCnt), PFM_DIV) ? '0
                            : st_r.pfmCnt + PFM_CW'(1);
        end

        // --------------------------------------------------------------
        // sequencer
        // --------------------------------------------------------------
        case (st_r.seq)
            SEQ_RESET: begin
                st_nxt.seqCnt = '0;
                if (!fault) begin
                    st_nxt.seq = SEQ_POWERUP;
                end
            end
            SEQ_POWERUP: begin
                if (atLast(32'(st_r.seqCnt), SEQ_CYC)) begin
                    st_nxt.seq = SEQ_ACTIVE;
                end else begin
                    st_nxt.seqCnt = st_r.seqCnt + SEQ_CW'(1);
                end
            end
            SEQ_ACTIVE: begin
                st_nxt.seqCnt = '0;
            end
            default: begin
                st_nxt.seq = SEQ_RESET;
            end
        endcase

        // --------------------------------------------------------------
        // soft start
        // --------------------------------------------------------------
        // per-channel soft start; a stopped channel restarts from step 0
        for (int i = 0; i < NUM_CHAN; i++) begin
            st_nxt.out.chanRun[i] = chanGo[i];
            if (!chanGo[i]) begin
                st_nxt.ssCnt[i] = '0;
                st_nxt.out.limitStep[i] = '0;
            end else if (st_r.out.limitStep[i] != STEP_MAX) begin
                if (atLast(32'(st_r.ssCnt[i]), SS_STEP_CYC)) begin
                    st_nxt.ssCnt[i] = '0;
                    st_nxt.out.limitStep[i] =
                        st_r.out.limitStep[i] + STEP_W'(1);
                end else begin
                    st_nxt.ssCnt[i] = st_r.ssCnt[i] + SS_CW'(1);
                end
            end
        end

        // --------------------------------------------------------------
        // buck switch control
        // --------------------------------------------------------------
        for (int b = 0; b < NUM_BUCK; b++) begin
            st_nxt.out.pulseFrequencyOperation[b] = s.lightLoad[b];
            // short: high side stays off until the inductor current decays
            if (!chanGo[b] || s.currentLow[b]) begin
                st_nxt.shortHold[b] = 1'b0;
            end
            if (chanGo[b] && s.shortDetect[b]) begin
                st_nxt.shortHold[b] = 1'b1;
            end
            if (!chanGo[b] || st_nxt.shortHold[b] || s.currentTrip[b]) begin
                st_nxt.out.highSide[b] = 1'b0;
            end else if (s.lightLoad[b] ? pfmTick : swTick) begin
                st_nxt.out.highSide[b] = 1'b1;
            end
            st_nxt.out.lowSide[b] = chanGo[b] & ~st_nxt.out.highSide[b];
        end

        // --------------------------------------------------------------
        // boost
        // --------------------------------------------------------------
        // boost output level follows the select pin while enabled
        st_nxt.out.lnbRun = (st_r.seq == SEQ_ACTIVE) & s.lnbSupplyOk
                            & s.lnbBoostEnable;
        st_nxt.out.lnbHighLevel = st_nxt.out.lnbRun & s.lnbLevelSelect;

        // --------------------------------------------------------------
        // host reset timer
        // --------------------------------------------------------------
        // host reset release timer; any loss restarts it from zero
        if (!s.chanEnable[CH_HV2] || !s.hvReg2OutputGood
            || !chanGo[CH_HV2]) begin
            st_nxt.porCnt = '0;
            st_nxt.porRelease = 1'b0;
        end else if (atLast(32'(st_r.porCnt), PorDelayCyc)) begin
            st_nxt.porRelease = 1'b1;
        end else begin
            st_nxt.porCnt = st_r.porCnt + POR_CW'(1);
        end

        // --------------------------------------------------------------
        // fault
        // --------------------------------------------------------------
        // clearing on every fault cycle, not only on entry, means even a
        // one-cycle fault leaves nothing behind for the next start-up
        // a fault wipes everything except the synchronisers and the switching timebase
        if (fault) begin
            st_nxt.seq = SEQ_RESET;
            st_nxt.seqCnt = '0;
            st_nxt.ssCnt = '0;
            st_nxt.shortHold = '0;
            st_nxt.porCnt = '0;
            st_nxt.porRelease = 1'b0;
            st_nxt.out = '0;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // the asynchronous branch loads only constants; all-zero state is the
    // reset sequencer state with the host reset pin pulled low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // enable dropping bypasses the timer flop so the pin falls at once;
    // the trade is a combinational pin enable behind the synchroniser
    assign porOe = ~st_r.porRelease | ~s.chanEnable[CH_HV2];
    assign porOut = 1'b0;
    assign ctrlOut = st_r.out;
    assign seqState = st_r.seq;
endmodule // pss_supervisor_sequencer

// [verification/pss_host_model.sv]
// model: host processor watching the open-drain reset pin
`timescale 1ns/1ps
module pss_host_model (
    // open-drain reset pin
    input wire logic porOe,
    input wire logic porOut,
    // host view
    output logic hostInReset
);
    // only the pull-up makes a high level; nobody else drives it
    assign hostInReset = porOe ? !porOut : 1'b0;
endmodule // pss_host_model

// [verification/pss_supervisor_sequencer_assertions.sv]
// checker: timing properties on the supervisor sequencer ports
`timescale 1ns/1ps
module pss_supervisor_sequencer_assertions
    import pss_pkg::*;
#(
    parameter int PorDelayCyc = pss_pkg::POR_DELAY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire pss_pkg::pss_in_t pinIn,
    input wire pss_pkg::pss_out_t ctrlOut,
    input wire logic porOut,
    input wire logic porOe,
    input wire pss_pkg::pss_seq_t seqState
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] goodRun_r;
    // run of good hv2 pin levels; release may not come sooner than this
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            goodRun_r <= 32'h0;
        end else if (pinIn.hvReg2OutputGood && pinIn.chanEnable[CH_HV2]) begin
            goodRun_r <= goodRun_r + 32'h1;
        end else begin
            goodRun_r <= 32'h0;
        end
    end
    // input levels held through the two-flop synchroniser
    sequence hotHeld; pinIn.overTemp [*3]; endsequence
    sequence overHeld; (|pinIn.supplyOver) [*3]; endsequence
    sequence hv2Off; (!pinIn.chanEnable[CH_HV2]) [*3]; endsequence
    por_drive_low_a: assert property (porOut == 1'b0)
        else $error("reset pin data not low");
    por_enable_low_a: assert property (hv2Off |-> porOe)
        else $error("reset pin released with hv2 disabled");
    por_release_delay_a: assert property ($fell(porOe) |->
        goodRun_r >= 32'(PorDelayCyc)) else $error("reset released early");
    heat_reset_a: assert property (hotHeld |=> seqState == SEQ_RESET)
        else $error("no reset state while hot");
    over_reset_a: assert property (overHeld |=> seqState == SEQ_RESET)
        else $error("no reset state on overvoltage");
    reset_off_a: assert property ((seqState == SEQ_RESET) [*2]
        |-> ctrlOut.chanRun == '0) else $error("channel running in reset");
    run_gate_a: assert property ((ctrlOut.chanRun & ~$past(ctrlOut.chanRun)
        & ~$past(pinIn.supplyOk & pinIn.chanEnable, 3)) == '0)
        else $error("channel started without supply and enable");
    step_start_a: assert property ($rose(ctrlOut.chanRun[0])
        |-> ctrlOut.limitStep[0] == '0) else $error("soft start not at zero");
    step_climb_a: assert property (ctrlOut.chanRun[0] && $past(ctrlOut.chanRun[0])
        |-> ({1'b0, ctrlOut.limitStep[0]} - {1'b0, $past(ctrlOut.limitStep[0])})
        <= 4'h1) else $error("current limit jumped");
    pfm_light_a: assert property (ctrlOut.pulseFrequencyOperation[0]
        |-> $past(pinIn.lightLoad[0], 3)) else $error("pfm without light load");
    lnb_level_a: assert property (ctrlOut.lnbRun && $past(ctrlOut.lnbRun)
        |-> ctrlOut.lnbHighLevel == $past(pinIn.lnbLevelSelect, 3))
        else $error("lnb level does not follow select");
endmodule // pss_supervisor_sequencer_assertions
bind pss_supervisor_sequencer pss_supervisor_sequencer_assertions #(
    .PorDelayCyc(PorDelayCyc)
) i_pss_supervisor_sequencer_assertions (.clk(clk), .rst(rst),
    .pinIn(pinIn), .ctrlOut(ctrlOut), .porOut(porOut), .porOe(porOe),
    .seqState(seqState));

// [verification/test_pss_supervisor_sequencer.sv]
// testbench: supervisor sequencer with random and corner stimulus
`timescale 1ns/1ps
module test_pss_supervisor_sequencer;
    import pss_pkg::*;
    localparam int PorCyc = 100; // short release delay keeps the run brief
    logic clk;
    logic rst;
    pss_in_t pins;
    pss_out_t ctrl;
    logic porOut;
    logic porOe;
    pss_seq_t state;
    logic hostInReset;
    int nMismatch;
    int cmpCount;
    int seed;
    int i;
    pss_supervisor_sequencer #(.PorDelayCyc(PorCyc)) i_pss_supervisor_sequencer (
        .clk(clk), .rst(rst), .pinIn(pins), .ctrlOut(ctrl), .porOut(porOut),
        .porOe(porOe), .seqState(state));
    pss_host_model i_pss_host_model (.porOe(porOe), .porOut(porOut),
        .hostInReset(hostInReset));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [5:0] expRun(input logic [5:0] ok, en);
        return ok & en;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, got);
        cmpCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tallyAndFinish();
        $display("compares %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // bounded wait; the power-up walk takes about 2500 cycles
    task automatic waitActive();
        int t = 0;
        while (state !== SEQ_ACTIVE && t < 4000) begin
            cyc(1);
            t++;
        end
        if (t == 4000) begin
            chk("seqState", 32'(SEQ_ACTIVE), 32'(state));
            tallyAndFinish();
        end
        cyc(4);
    endtask
    initial begin
        seed = 32'hd6b9;
        nMismatch = 0;
        cmpCount = 0;
        pins = '0;
        rst = 1'b1;
        cyc(12);
        rst = 1'b0;
        pins.supplyOk = 6'h3F;
        pins.chanEnable = 6'h3F;
        pins.hvReg2OutputGood = 1'b1;
        pins.lnbSupplyOk = 1'b1;
        pins.lnbBoostEnable = 1'b1;
        waitActive();
        chk("chanRun", 32'h3F, 32'(ctrl.chanRun));
        chk("limitStep", 32'h0, 32'(ctrl.limitStep));
        chk("hostInReset", 32'h1, 32'(hostInReset));
        cyc(PorCyc + 10);
        chk("hostInReset", 32'h0, 32'(hostInReset));
        $display("test power-up done");
        pins.chanEnable[CH_HV2] = 1'b0;
        cyc(3);
        chk("hostInReset", 32'h1, 32'(hostInReset));
        pins.chanEnable[CH_HV2] = 1'b1;
        cyc(60);
        pins.hvReg2OutputGood = 1'b0; // dip before the delay runs out
        cyc(3);
        pins.hvReg2OutputGood = 1'b1;
        cyc(60);
        chk("hostInReset", 32'h1, 32'(hostInReset));
        cyc(PorCyc);
        chk("hostInReset", 32'h0, 32'(hostInReset));
        $display("test reset monitor done");
        for (i = 0; i < 40; i++) begin
            pins.chanEnable = 6'($random(seed)) | 6'h02;
            pins.supplyOk = 6'($random(seed)) | 6'h02;
            pins.lightLoad = 4'($random(seed));
            {pins.currentTrip, pins.shortDetect, pins.currentLow} =
                12'($random(seed));
            pins.lnbLevelSelect = 1'($random(seed));
            cyc(4);
            chk("chanRun", 32'(expRun(pins.supplyOk, pins.chanEnable)),
                32'(ctrl.chanRun));
            chk("lnbHighLevel", 32'(pins.lnbLevelSelect),
                32'(ctrl.lnbHighLevel));
            chk("pulseFrequencyOperation", 32'(pins.lightLoad),
                32'(ctrl.pulseFrequencyOperation));
            chk("highSide", 32'h0, 32'(ctrl.highSide
                & (pins.shortDetect | pins.currentTrip)));
        end
        pins.supplyOk = 6'h3F;
        pins.chanEnable = 6'h3F;
        $display("test random channels done");
        // overheating, then overvoltage on each hv supply
        for (i = 0; i < 3; i++) begin
            pins.overTemp = (i == 0);
            pins.supplyOver = 2'(i);
            cyc(5);
            chk("seqState", 32'(SEQ_RESET), 32'(state));
            chk("chanRun", 32'h0, 32'(ctrl.chanRun));
            chk("hostInReset", 32'h1, 32'(hostInReset));
            pins.overTemp = 1'b0;
            pins.supplyOver = 2'h0;
            waitActive();
            chk("limitStep", 32'h0, 32'(ctrl.limitStep));
        end
        $display("test faults done");
        tallyAndFinish();
    end
endmodule // test_pss_supervisor_sequencer
